// ==== design/auto_function_control.sv ====
// automatic image-property control: mode sequencing, statistics window, value override
// assumes pixels arrive on clk_i with in-frame coordinates (binned when binning is on)
//
// Operation
// - sequencer enabled keeps all functions off
// - running function overwrites manual parameter value
// - adjustments clamped between lower and upper limits
// - unreachable target: approach nearest limit, no stall
// - several functions adjust concurrently
// - binned pixels feed statistics under binning
// - once mode reaches target then self-offs
// - once mode gives up after 30 frames
// - continuous mode adjusts every frame
// - leaving continuous keeps last automatic value
// - settings accepted during capture
// - new mode may apply from next frame
// - window coordinates start at column/row zero
// - window is offset, width, height rectangle
// - stats from window/capture intersection only
// - no intersection means no control
// - reset window covers full sensor
// - window fields accept single steps
// - binned mode coordinates in binned units
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module auto_function_control #(
   parameter int N = afc_pkg::N_FUNC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // pixel stream
   input wire logic pix_valid_i,
   input wire afc_pkg::pix_s pix_i,
   // controlled parameter values
   output logic [afc_pkg::VAL_W-1:0] value0_o,
   output logic [afc_pkg::VAL_W-1:0] value1_o
);
   localparam int CW = afc_pkg::COORD_W;
   localparam int VW = afc_pkg::VAL_W;

   // register state
   logic [31:0] ctrl, next_ctrl;
   afc_pkg::span_s win_col, win_row, cap_col, cap_row;
   afc_pkg::span_s next_win_col, next_win_row, next_cap_col, next_cap_row;
   logic [7:0] target, next_target;
   logic [2*VW-1:0] limit [N];
   logic [2*VW-1:0] next_limit [N];
   logic [VW-1:0] value [N];
   logic [VW-1:0] next_value [N];
   logic [N-1:0] man_wr;
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic [1:0] mode_f [N];

   // frame state
   afc_pkg::span_s ix_col, ix_row, next_ix_col, next_ix_row;
   logic ix_ok, next_ix_ok;
   logic [31:0] sum, next_sum;
   logic [23:0] cnt, next_cnt;
   logic [4:0] once_cnt [N];
   logic [4:0] next_once_cnt [N];
   logic [N-1:0] done_off, next_done_off;

   logic req;
   assign req = cyc_i && stb_i && !ack;
   wire seq_on = ctrl[afc_pkg::CTRL_SEQ_BIT];
   wire [7:0] damp = ctrl[afc_pkg::CTRL_DAMP_LSB +: 8];

   // register writes, accepted any time including mid-frame
   always_comb begin
      next_ctrl = ctrl;
      next_win_col = win_col;
      next_win_row = win_row;
      next_cap_col = cap_col;
      next_cap_row = cap_row;
      next_target = target;
      next_ack = req;
      next_rdata = rdata;
      man_wr = '0;
      for (int i = 0; i < N; i++) begin
         next_limit[i] = limit[i];
      end
      if (req && we_i && sel_i == 4'hf) begin
         case (adr_i)
            afc_pkg::ADDR_CTRL: next_ctrl = dat_i;
            afc_pkg::ADDR_WIN_COL: next_win_col = dat_i[2*CW-1:0];
            afc_pkg::ADDR_WIN_ROW: next_win_row = dat_i[2*CW-1:0];
            afc_pkg::ADDR_CAP_COL: next_cap_col = dat_i[2*CW-1:0];
            afc_pkg::ADDR_CAP_ROW: next_cap_row = dat_i[2*CW-1:0];
            afc_pkg::ADDR_TARGET: next_target = dat_i[7:0];
            afc_pkg::ADDR_LIMIT0: next_limit[0] = dat_i;
            afc_pkg::ADDR_LIMIT1: next_limit[1] = dat_i;
            afc_pkg::ADDR_MANUAL0: man_wr[0] = 1'b1;
            afc_pkg::ADDR_MANUAL1: man_wr[1] = 1'b1;
            default: ;
         endcase
      end
      // self-clear of once mode when done; hardware clear wins over software
      for (int i = 0; i < N; i++) begin
         if (done_off[i]) begin
            next_ctrl[2*i +: 2] = 2'(afc_pkg::MODE_OFF);
         end
      end
      if (req && !we_i) begin
         case (adr_i)
            afc_pkg::ADDR_CTRL: next_rdata = ctrl;
            afc_pkg::ADDR_WIN_COL: next_rdata = 32'(win_col);
            afc_pkg::ADDR_WIN_ROW: next_rdata = 32'(win_row);
            afc_pkg::ADDR_CAP_COL: next_rdata = 32'(cap_col);
            afc_pkg::ADDR_CAP_ROW: next_rdata = 32'(cap_row);
            afc_pkg::ADDR_TARGET: next_rdata = 32'(target);
            afc_pkg::ADDR_LIMIT0: next_rdata = limit[0];
            afc_pkg::ADDR_LIMIT1: next_rdata = limit[1];
            afc_pkg::ADDR_VALUE0, afc_pkg::ADDR_MANUAL0: next_rdata = 32'(value[0]);
            afc_pkg::ADDR_VALUE1, afc_pkg::ADDR_MANUAL1: next_rdata = 32'(value[1]);
            afc_pkg::ADDR_STATUS: next_rdata = {31'h0, ix_ok};
            default: next_rdata = 32'h0;
         endcase
      end
   end

   // register flops; window resets to the full sensor
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= 32'h0;
         win_col <= '{start: '0, len: afc_pkg::SENSOR_COLS};
         win_row <= '{start: '0, len: afc_pkg::SENSOR_ROWS};
         cap_col <= '{start: '0, len: afc_pkg::SENSOR_COLS};
         cap_row <= '{start: '0, len: afc_pkg::SENSOR_ROWS};
         target <= afc_pkg::TARGET_RST;
         ack <= 1'b0;
         rdata <= 32'h0;
         for (int i = 0; i < N; i++) begin
            limit[i] <= {afc_pkg::LIMIT_HI_RST, 16'h0};
         end
      end else begin
         ctrl <= next_ctrl;
         win_col <= next_win_col;
         win_row <= next_win_row;
         cap_col <= next_cap_col;
         cap_row <= next_cap_row;
         target <= next_target;
         ack <= next_ack;
         rdata <= next_rdata;
         for (int i = 0; i < N; i++) begin
            limit[i] <= next_limit[i];
         end
      end
   end
   assign ack_o = ack;
   assign dat_o = rdata;

   // effective modes: the sequencer forces every function off
   always_comb begin
      for (int i = 0; i < N; i++) begin
         mode_f[i] = seq_on ? 2'(afc_pkg::MODE_OFF) : ctrl[2*i +: 2];
      end
   end

   // intersection of the two windows, taken at frame start
   function automatic afc_pkg::span_s isect(input afc_pkg::span_s a, input afc_pkg::span_s b);
      logic [CW:0] ea, eb, s, e;
      afc_pkg::span_s res;
      ea = {1'b0, a.start} + {1'b0, a.len};
      eb = {1'b0, b.start} + {1'b0, b.len};
      s = (a.start > b.start) ? {1'b0, a.start} : {1'b0, b.start};
      e = (ea < eb) ? ea : eb;
      // an empty overlap comes back with zero length, start kept for reading
      res.start = s[CW-1:0];
      res.len = (e > s) ? CW'(e - s) : '0;
      return res;
   endfunction

   wire in_win = pix_valid_i
      && pix_i.col >= ix_col.start && pix_i.col < ix_col.start + ix_col.len
      && pix_i.row >= ix_row.start && pix_i.row < ix_row.start + ix_row.len;

   // statistics accumulation; pixels are already binned when binning is on
   always_comb begin
      afc_pkg::span_s c, r;
      c = isect(win_col, cap_col);
      r = isect(win_row, cap_row);
      next_ix_col = ix_col;
      next_ix_row = ix_row;
      next_ix_ok = ix_ok;
      next_sum = sum;
      next_cnt = cnt;
      if (pix_valid_i && pix_i.sof) begin
         next_ix_col = c;
         next_ix_row = r;
         next_ix_ok = c.len != '0 && r.len != '0;
         next_sum = 32'h0;
         next_cnt = 24'h0;
      end else if (in_win) begin
         next_sum = sum + 32'(pix_i.data);
         next_cnt = cnt + 24'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ix_col <= '0;
         ix_row <= '0;
         ix_ok <= 1'b0;
         sum <= 32'h0;
         cnt <= 24'h0;
      end else begin
         ix_col <= next_ix_col;
         ix_row <= next_ix_row;
         ix_ok <= next_ix_ok;
         sum <= next_sum;
         cnt <= next_cnt;
      end
   end

   // mean over the window; the divide is combinational and only read at frame end,
   // but the last pixel can land one beat before eof, so it is a single-cycle path: a limitation for fast pixel clocks
   logic [7:0] mean;
   always_comb begin
      logic [31:0] q;
      q = (cnt != 24'h0) ? sum / 32'(cnt) : 32'h0;
      mean = q[7:0];
   end
   wire frame_end = pix_valid_i && pix_i.eof;
   // error to target, shifted by damping; a step of at least one keeps an
   // unreachable target from stalling the value short of its limit
   wire [7:0] err = (mean > target) ? mean - target : target - mean;
   wire [VW-1:0] shifted = VW'({8'h0, err} >> damp[3:0]);
   wire [VW-1:0] step = (shifted == '0) ? VW'(1) : shifted;
   wire close_enough = err <= afc_pkg::TOL;

   // per-function adjustment, each function independent
   generate
      for (genvar g = 0; g < N; g++) begin : fn
         always_comb begin
            logic [VW-1:0] lo, hi, v;
            lo = limit[g][VW-1:0];
            hi = limit[g][2*VW-1:VW];
            v = value[g];
            next_value[g] = value[g];
            next_once_cnt[g] = once_cnt[g];
            next_done_off[g] = 1'b0;
            if (man_wr[g]) begin
               next_value[g] = dat_i[VW-1:0];
            end else if (frame_end && mode_f[g] != 2'(afc_pkg::MODE_OFF) && ix_ok) begin
               if (!close_enough) begin
                  if (mean < target) begin
                     v = (hi - value[g] < step) ? hi : value[g] + step;
                  end else begin
                     v = (value[g] - lo < step) ? lo : value[g] - step;
                  end
               end
               if (v > hi) v = hi;
               if (v < lo) v = lo;
               next_value[g] = v;
               if (mode_f[g] == 2'(afc_pkg::MODE_ONCE)) begin
                  next_once_cnt[g] = once_cnt[g] + 5'h1;
                  if (close_enough || once_cnt[g] + 5'h1 >= afc_pkg::ONCE_MAX_FRAMES) begin
                     next_done_off[g] = 1'b1;
                     next_once_cnt[g] = 5'h0;
                  end
               end
            end else if (mode_f[g] != 2'(afc_pkg::MODE_ONCE)) begin
               next_once_cnt[g] = 5'h0;
            end
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               value[g] <= afc_pkg::VALUE_RST;
               once_cnt[g] <= 5'h0;
               done_off[g] <= 1'b0;
            end else begin
               value[g] <= next_value[g];
               once_cnt[g] <= next_once_cnt[g];
               done_off[g] <= next_done_off[g];
            end
         end
         // value stays between limits once it moved automatically
         a_value_in_limits: assert property (@(posedge clk_i) disable iff (rst_i)
            $rose(frame_end) && mode_f[g] != 2'(afc_pkg::MODE_OFF) && ix_ok && !man_wr[g]
            && limit[g][VW-1:0] <= limit[g][2*VW-1:VW]
            |=> value[g] >= limit[g][VW-1:0] && value[g] <= limit[g][2*VW-1:VW])
            else $error("auto value outside limits");
         a_once_bound: assert property (@(posedge clk_i) disable iff (rst_i)
            once_cnt[g] < afc_pkg::ONCE_MAX_FRAMES)
            else $error("once mode ran past frame bound");
         a_done_offs: assert property (@(posedge clk_i) disable iff (rst_i)
            done_off[g] |=> ctrl[2*g +: 2] == 2'(afc_pkg::MODE_OFF))
            else $error("once mode did not switch off");
         a_off_holds: assert property (@(posedge clk_i) disable iff (rst_i)
            mode_f[g] == 2'(afc_pkg::MODE_OFF) && !man_wr[g] && !done_off[g]
            |=> $stable(value[g]))
            else $error("value changed while function off");

         // once mode that lands in tolerance raises done_off next cycle
         a_once_reached: assert property (@(posedge clk_i) disable iff (rst_i)
            frame_end && mode_f[g] == 2'(afc_pkg::MODE_ONCE) && ix_ok && !man_wr[g]
            && close_enough |=> done_off[g])
            else $error("once mode missed its target stop");
         // the thirtieth adjusted frame always ends once mode
         a_once_limit: assert property (@(posedge clk_i) disable iff (rst_i)
            frame_end && mode_f[g] == 2'(afc_pkg::MODE_ONCE) && ix_ok && !man_wr[g]
            && once_cnt[g] == afc_pkg::ONCE_MAX_FRAMES - 5'h1 |=> done_off[g])
            else $error("once mode kept going past frame bound");
         // only once mode may clear its own mode bits
         a_no_self_off: assert property (@(posedge clk_i) disable iff (rst_i)
            mode_f[g] != 2'(afc_pkg::MODE_ONCE) |=> !done_off[g])
            else $error("mode cleared outside once mode");
         // a manual write replaces the value in the next cycle
         a_manual_lands: assert property (@(posedge clk_i) disable iff (rst_i)
            man_wr[g] |=> value[g] == VW'($past(dat_i)))
            else $error("manual value not applied");
         // sequencer freezes every function, not only the first
         a_seq_holds: assert property (@(posedge clk_i) disable iff (rst_i)
            seq_on && !man_wr[g] |=> $stable(value[g]))
            else $error("function moved with sequencer enabled");
         // nothing but a manual write or a frame end moves the value
         a_value_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
            !man_wr[g] && !frame_end |=> $stable(value[g]))
            else $error("value moved between frame ends");
      end
   endgenerate

   assign value0_o = value[0];
   assign value1_o = value[1];

   a_seq_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_on && !man_wr[0] |=> $stable(value[0]))
      else $error("function ran with sequencer enabled");
   a_no_overlap: assert property (@(posedge clk_i) disable iff (rst_i)
      !ix_ok && !man_wr[0] |=> $stable(value[0]))
      else $error("control without window overlap");
   a_stats_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      pix_valid_i && !pix_i.sof && !in_win |=> $stable(cnt))
      else $error("pixel outside intersection counted");
   a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held more than one cycle");

   // every request seen with ack low is answered in the next cycle
   a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acknowledged");
   // no answer without a request standing
   a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
      !(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   // read data stands until the next read is taken
   a_rdata_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      !(cyc_i && stb_i && !ack_o && !we_i) |=> $stable(dat_o))
      else $error("read data changed without a read");
   // status reports the overlap latched at the last frame start
   a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
      cyc_i && stb_i && !ack_o && !we_i && adr_i == afc_pkg::ADDR_STATUS
      |=> dat_o == {31'h0, $past(ix_ok)})
      else $error("status read does not match overlap");
   // the intersection only moves at a frame start
   a_window_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
      !(pix_valid_i && pix_i.sof) |=> $stable(ix_col) && $stable(ix_row) && $stable(ix_ok))
      else $error("intersection changed mid-frame");
   // frame start clears the statistics
   a_sof_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      pix_valid_i && pix_i.sof |=> sum == 32'h0 && cnt == 24'h0)
      else $error("statistics not cleared at frame start");
   // each pixel inside the intersection is counted once
   a_window_counts: assert property (@(posedge clk_i) disable iff (rst_i)
      in_win && !pix_i.sof |=> cnt == $past(cnt) + 24'h1)
      else $error("pixel inside intersection not counted");
endmodule

// ==== design/afc_pkg.sv ====
// package for the automatic image-property control block
// assumes a wishbone classic slave with 32-bit data and byte addresses
package afc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WIN_COL = 8'h04;
   localparam logic [7:0] ADDR_WIN_ROW = 8'h08;
   localparam logic [7:0] ADDR_CAP_COL = 8'h0c;
   localparam logic [7:0] ADDR_CAP_ROW = 8'h10;
   localparam logic [7:0] ADDR_TARGET = 8'h14;
   localparam logic [7:0] ADDR_LIMIT0 = 8'h18;
   localparam logic [7:0] ADDR_LIMIT1 = 8'h1c;
   localparam logic [7:0] ADDR_MANUAL0 = 8'h20;
   localparam logic [7:0] ADDR_MANUAL1 = 8'h24;
   localparam logic [7:0] ADDR_VALUE0 = 8'h28;
   localparam logic [7:0] ADDR_VALUE1 = 8'h2c;
   localparam logic [7:0] ADDR_STATUS = 8'h30;
   // control field positions
   localparam int CTRL_MODE0_LSB = 0;
   localparam int CTRL_MODE1_LSB = 2;
   localparam int CTRL_SEQ_BIT = 4;
   localparam int CTRL_BIN_BIT = 5;
   localparam int CTRL_DAMP_LSB = 8;
   // geometry and values
   localparam int COORD_W = 12;
   localparam int VAL_W = 16;
   localparam int PIX_W = 8;
   localparam logic [11:0] SENSOR_COLS = 12'h288;
   localparam logic [11:0] SENSOR_ROWS = 12'h1e8;
   localparam logic [4:0] ONCE_MAX_FRAMES = 5'h1e;
   localparam logic [15:0] LIMIT_HI_RST = 16'hffff;
   localparam logic [15:0] VALUE_RST = 16'h0100;
   localparam logic [7:0] TARGET_RST = 8'h80;
   localparam logic [7:0] TOL = 8'h02;
   localparam int N_FUNC = 2;
   // function modes
   typedef enum logic [1:0] {MODE_OFF, MODE_ONCE, MODE_CONT} mode_e;
   // one axis of a window: start and length
   typedef struct packed {
      logic [COORD_W-1:0] start;
      logic [COORD_W-1:0] len;
   } span_s;
   // one pixel beat from the pipeline
   typedef struct packed {
      logic sof;
      logic eof;
      logic [COORD_W-1:0] col;
      logic [COORD_W-1:0] row;
      logic [PIX_W-1:0] data;
   } pix_s;
endpackage

// ==== tb/afc_pixel_source.sv ====
// pixel pipeline model: one raster of 8 columns by 4 rows per start pulse
// assumes the block takes a beat on every rising edge while valid is high
`timescale 1ns/1ps
module afc_pixel_source (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // frame request and scene: dark left of the split column, bright from it
   input wire logic start_i,
   input wire logic [11:0] split_i,
   input wire logic [7:0] lo_i,
   input wire logic [7:0] hi_i,
   // pixel stream towards the block
   output logic pix_valid_o,
   output afc_pkg::pix_s pix_o,
   output logic busy_o
);
   logic [11:0] col;
   logic [11:0] row;

   // sof beat, raster, eof beat; idle lines toggle so no stale beat looks real
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         pix_valid_o <= 1'b0;
         pix_o <= '0;
         col <= 12'h000;
         row <= 12'h000;
      end else if (!busy_o) begin
         pix_valid_o <= start_i;
         pix_o <= start_i ? afc_pkg::pix_s'{1'b1, 1'b0, 12'h000, 12'h000, lo_i} : ~pix_o;
         busy_o <= start_i;
         col <= 12'h000;
         row <= 12'h000;
      end else if (row == 12'h004) begin
         pix_o <= afc_pkg::pix_s'{1'b0, 1'b1, 12'h000, 12'h000, lo_i};
         busy_o <= 1'b0;
      end else begin
         pix_o <= afc_pkg::pix_s'{1'b0, 1'b0, col, row, (col >= split_i) ? hi_i : lo_i};
         col <= (col == 12'h007) ? 12'h000 : col + 12'h001;
         row <= (col == 12'h007) ? row + 12'h001 : row;
      end
   end
endmodule

// ==== tb/auto_function_control_bench.sv ====
// self-checking bench for the automatic property control block
// assumes the pixel source model, a 50 MHz clock and synchronous reset
`timescale 1ns/1ps
`define CHECK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
      end \
   end
module auto_function_control_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat_w = 32'h0;
   logic [31:0] dat_r;
   logic ack;
   logic pix_valid;
   afc_pkg::pix_s pix;
   logic [15:0] v0;
   logic [15:0] v1;
   logic start = 1'b0;
   logic [11:0] split = 12'hfff;
   logic [7:0] lo = 8'h40;
   logic [7:0] hi = 8'hff;
   logic busy;
   logic [31:0] junk;
   int n_mismatch = 0;
   int total_checks = 0;

   // 50 MHz clock
   always #10 clk_i = ~clk_i;

   auto_function_control i_auto_function_control (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
      .pix_valid_i(pix_valid), .pix_i(pix), .value0_o(v0), .value1_o(v1));

   afc_pixel_source i_afc_pixel_source (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .split_i(split), .lo_i(lo),
      .hi_i(hi), .pix_valid_o(pix_valid), .pix_o(pix), .busy_o(busy));

   // verdict and end of run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // one classic cycle, held until ack is seen at a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= s;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hf, junk);
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hf, q);
      `CHECK(q, e)
   endtask

   // whole frames; settle time covers value and mode updates after eof
   task automatic frames(input int n, input logic [7:0] l);
      lo <= l;
      repeat (n) begin
         start <= 1'b1;
         @(posedge clk_i);
         start <= 1'b0;
         @(posedge clk_i);
         while (busy === 1'b1) @(posedge clk_i);
         repeat (4) @(posedge clk_i);
      end
   endtask

   // watchdog: about 40 frames and 31 bus cycles should fit well inside
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      give_verdict();
   end

   // main sequence: each adjusted frame steps the value by |mean - target| >> damping (at least one), clamped to the limits
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(afc_pkg::ADDR_CTRL, 32'h0);
      // window words carry start in bits 23:12 and length in bits 11:0
      chk(afc_pkg::ADDR_WIN_COL, 32'h00000288);
      chk(afc_pkg::ADDR_WIN_ROW, 32'h000001e8);
      chk(afc_pkg::ADDR_TARGET, 32'h80);
      chk(afc_pkg::ADDR_LIMIT0, 32'hffff0000);
      chk(afc_pkg::ADDR_VALUE1, 32'h100);
      chk(8'h3c, 32'h0);
      `CHECK(v0, 16'h0100)
      // partial byte enables are dropped
      wb(1'b1, afc_pkg::ADDR_TARGET, 32'h10, 4'h3, junk);
      chk(afc_pkg::ADDR_TARGET, 32'h80);
      // limits first, then continuous mode pulls the manual value upward
      wr(afc_pkg::ADDR_LIMIT0, 32'h02800100);
      wr(afc_pkg::ADDR_MANUAL0, 32'h200);
      `CHECK(v0, 16'h0200)
      wr(afc_pkg::ADDR_CTRL, 32'h2);
      frames(1, 8'h40);
      `CHECK(v0, 16'h0240)
      frames(2, 8'h40);
      `CHECK(v0, 16'h0280)
      // leaving continuous keeps the last automatic value until a manual write
      wr(afc_pkg::ADDR_CTRL, 32'h0);
      frames(1, 8'h40);
      chk(afc_pkg::ADDR_VALUE0, 32'h280);
      wr(afc_pkg::ADDR_MANUAL0, 32'h100);
      `CHECK(v0, 16'h0100)
      // bright columns outside the statistics window must be ignored
      split <= 12'h004;
      wr(afc_pkg::ADDR_WIN_COL, 32'h00000004);
      wr(afc_pkg::ADDR_CTRL, 32'h2);
      frames(1, 8'h40);
      `CHECK(v0, 16'h0140)
      // same through a narrow capture window
      wr(afc_pkg::ADDR_WIN_COL, 32'h00000288);
      wr(afc_pkg::ADDR_CAP_COL, 32'h00000004);
      frames(1, 8'h40);
      `CHECK(v0, 16'h0180)
      chk(afc_pkg::ADDR_STATUS, 32'h1);
      // disjoint windows: no control
      wr(afc_pkg::ADDR_WIN_COL, 32'h00010004);
      frames(1, 8'h40);
      `CHECK(v0, 16'h0180)
      chk(afc_pkg::ADDR_STATUS, 32'h0);
      wr(afc_pkg::ADDR_WIN_COL, 32'h00000288);
      wr(afc_pkg::ADDR_CAP_COL, 32'h00000288);
      split <= 12'hfff;
      // sequencer enabled holds the running function 0 still
      wr(afc_pkg::ADDR_CTRL, 32'h12);
      frames(1, 8'h40);
      `CHECK(v0, 16'h0180)
      // both functions at once, binning flag, damping shift of one
      wr(afc_pkg::ADDR_CTRL, 32'h12a);
      frames(1, 8'h40);
      `CHECK(v0, 16'h01a0)
      `CHECK(v1, 16'h0120)
      // once mode against an unreachable target gives up after 30 frames
      wr(afc_pkg::ADDR_CTRL, 32'h1);
      frames(29, 8'h40);
      chk(afc_pkg::ADDR_CTRL, 32'h1);
      frames(1, 8'h40);
      chk(afc_pkg::ADDR_CTRL, 32'h0);
      `CHECK(v0, 16'h0280)
      // once mode with the target already met turns itself off
      wr(afc_pkg::ADDR_CTRL, 32'h1);
      frames(1, 8'h7f);
      chk(afc_pkg::ADDR_CTRL, 32'h0);
      give_verdict();
   end
endmodule
